// *** hdl/crg_pkg.sv ***
`default_nettype none
package crg_pkg;

  // ---------------------------------------------------------------------
  // Guard patterns held in the dedicated flash word (values arbitrary)
  // ---------------------------------------------------------------------
  localparam logic [31:0] LEVEL_ONE_PATTERN = 32'h12345678;
  localparam logic [31:0] LEVEL_TWO_PATTERN = 32'h87654321;
  localparam logic [31:0] LEVEL_THREE_PATTERN = 32'h43218765;

  // ---------------------------------------------------------------------
  // Boot-loader command classes
  // ---------------------------------------------------------------------
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_ERASE_PART = 3'h2;
  localparam logic [2:0] CMD_ERASE_ALL = 3'h3;
  localparam logic [2:0] CMD_GO = 3'h4;
  localparam logic [2:0] CMD_INFO = 3'h5;
  localparam int SECT_W = 5;
  localparam logic [4:0] PROTECTED_SECTOR = 5'h00;
  localparam logic [31:0] FLASH_WORD_RESET = 32'hFFFFFFFF;

  typedef enum logic [3:0] {
    CRG_LVL_NONE = 4'h1,
    CRG_LVL_ONE = 4'h2,
    CRG_LVL_TWO = 4'h4,
    CRG_LVL_THREE = 4'h8
  } crg_level_e;

  localparam crg_level_e LEVEL_RESET = CRG_LVL_THREE;

  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [4:0] sector;
  } crg_req_s;

  typedef struct packed {
    logic accept;
    logic refuse;
  } crg_ans_s;

  typedef struct packed {
    crg_level_e level;
    logic erased_all;
    logic jtag_en;
    logic override_en;
    logic test_en;
    logic grant;
    crg_ans_s ans;
  } crg_state_s;

endpackage : crg_pkg
`default_nettype wire

// *** hdl/crg_level_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module crg_level_decode (
  input wire logic [31:0] i_word,
  output crg_pkg::crg_level_e o_level
);

  // ---------------------------------------------------------------------
  // Pattern match, unknown values leave the part open
  // ---------------------------------------------------------------------
  always_comb begin
    case (i_word)
      crg_pkg::LEVEL_ONE_PATTERN: o_level = crg_pkg::CRG_LVL_ONE;
      crg_pkg::LEVEL_TWO_PATTERN: o_level = crg_pkg::CRG_LVL_TWO;
      crg_pkg::LEVEL_THREE_PATTERN: o_level = crg_pkg::CRG_LVL_THREE;
      default: o_level = crg_pkg::CRG_LVL_NONE;
    endcase
  end

endmodule : crg_level_decode
`default_nettype wire

// *** hdl/crg_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module crg_gate (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [31:0] i_guard_word,
  input wire logic i_loader_override_pin,
  input wire logic i_sw_loader_call,
  input wire logic i_sw_prog_req,
  input wire crg_pkg::crg_req_s i_req,
  output logic o_jtag_en,
  output logic o_override_en,
  output logic o_test_en,
  output logic o_sw_prog_grant,
  output logic o_accept,
  output logic o_refuse,
  output logic [3:0] o_level
);

  crg_pkg::crg_level_e level_dec;
  crg_pkg::crg_state_s st_reg;
  crg_pkg::crg_state_s st_next;

  crg_level_decode u_dec (
    .i_word(i_guard_word),
    .o_level(level_dec)
  );

  // ---------------------------------------------------------------------
  // Command check per level
  // ---------------------------------------------------------------------
  function automatic logic cmd_ok(input crg_pkg::crg_level_e lvl,
                                  input crg_pkg::crg_req_s r,
                                  input logic erased, input logic sw_call);
    logic ok;
    ok = 1'b0;
    case (lvl)
      crg_pkg::CRG_LVL_NONE: ok = 1'b1;
      crg_pkg::CRG_LVL_ONE: begin
        case (r.cmd)
          crg_pkg::CMD_WRITE, crg_pkg::CMD_ERASE_PART:
            ok = (r.sector != crg_pkg::PROTECTED_SECTOR);
          crg_pkg::CMD_ERASE_ALL: ok = 1'b0;
          crg_pkg::CMD_GO, crg_pkg::CMD_INFO: ok = 1'b1;
          default: ok = 1'b0;
        endcase
      end
      crg_pkg::CRG_LVL_TWO: begin
        case (r.cmd)
          crg_pkg::CMD_ERASE_ALL, crg_pkg::CMD_INFO: ok = 1'b1;
          crg_pkg::CMD_WRITE: ok = erased;
          default: ok = 1'b0;
        endcase
      end
      crg_pkg::CRG_LVL_THREE: ok = sw_call;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_ok

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.level = level_dec;
    if (level_dec != st_reg.level) begin
      st_next.erased_all = 1'b0;
    end
    st_next.jtag_en = (level_dec == crg_pkg::CRG_LVL_NONE);
    st_next.override_en = i_loader_override_pin &&
                          (level_dec != crg_pkg::CRG_LVL_THREE);
    st_next.test_en = (level_dec != crg_pkg::CRG_LVL_THREE);
    st_next.grant = i_sw_prog_req;
    st_next.ans.accept = 1'b0;
    st_next.ans.refuse = 1'b0;
    // A full erase only counts at the level that took it
    if (i_req.valid) begin
      if (cmd_ok(level_dec, i_req,
                 st_reg.erased_all && (level_dec == st_reg.level),
                 i_sw_loader_call)) begin
        st_next.ans.accept = 1'b1;
        if (i_req.cmd == crg_pkg::CMD_ERASE_ALL) begin
          st_next.erased_all = 1'b1;
        end
      end else begin
        st_next.ans.refuse = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg.level <= crg_pkg::LEVEL_RESET;
      st_reg.erased_all <= 1'b0;
      st_reg.jtag_en <= 1'b0;
      st_reg.override_en <= 1'b0;
      st_reg.test_en <= 1'b0;
      st_reg.grant <= 1'b0;
      st_reg.ans <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs straight from the state register
  // ---------------------------------------------------------------------
  assign o_jtag_en = st_reg.jtag_en;
  assign o_override_en = st_reg.override_en;
  assign o_test_en = st_reg.test_en;
  assign o_sw_prog_grant = st_reg.grant;
  assign o_accept = st_reg.ans.accept;
  assign o_refuse = st_reg.ans.refuse;
  assign o_level = st_reg.level;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking chk_cb @(posedge i_sys_clk);
  endclocking

  default disable iff (!i_arst_n);

  sequence open_seen;
    level_dec == crg_pkg::CRG_LVL_NONE;
  endsequence

  sequence lvl1_seen;
    level_dec == crg_pkg::CRG_LVL_ONE;
  endsequence

  sequence lvl2_seen;
    level_dec == crg_pkg::CRG_LVL_TWO;
  endsequence

  sequence lvl3_seen;
    level_dec == crg_pkg::CRG_LVL_THREE;
  endsequence

  sequence write_asked;
    i_req.valid && i_req.cmd == crg_pkg::CMD_WRITE;
  endsequence

  sequence part_erase_asked;
    i_req.valid && i_req.cmd == crg_pkg::CMD_ERASE_PART;
  endsequence

  sequence wipe_asked;
    i_req.valid && i_req.cmd == crg_pkg::CMD_ERASE_ALL;
  endsequence

  sequence sector0_hit;
    i_req.sector == crg_pkg::PROTECTED_SECTOR;
  endsequence

  // Full erase at level two, level held, then a write
  sequence wipe_then_write;
    lvl2_seen ##0 wipe_asked ##1 lvl2_seen ##1 lvl2_seen ##0 write_asked;
  endsequence

  lvl_track_a: assert property (
    1'b1 |=> o_level == $past(level_dec))
    else $error("level output does not follow the guard word");
  sw_prog_free_a: assert property (
    i_sw_prog_req |=> o_sw_prog_grant)
    else $error("software programming blocked");
  sw_prog_idle_a: assert property (
    !i_sw_prog_req |=> !o_sw_prog_grant)
    else $error("software programming grant without request");

  jtag_lvl1_a: assert property (
    lvl1_seen |=> !o_jtag_en)
    else $error("jtag open at level one");
  sect0_guard_a: assert property (
    lvl1_seen ##0 write_asked ##0 sector0_hit |=> o_refuse)
    else $error("sector zero written at level one");
  sect0_erase_a: assert property (
    lvl1_seen ##0 part_erase_asked ##0 sector0_hit |=> o_refuse)
    else $error("sector zero erased at level one");
  lvl1_update_a: assert property (
    lvl1_seen ##0 write_asked ##0
    (i_req.sector != crg_pkg::PROTECTED_SECTOR) |=> o_accept)
    else $error("sector update refused at level one");
  lvl1_no_wipe_a: assert property (
    lvl1_seen ##0 wipe_asked |=> o_refuse)
    else $error("full erase taken at level one");

  part_erase_a: assert property (
    lvl2_seen ##0 part_erase_asked |=> o_refuse && !o_jtag_en)
    else $error("partial erase at level two");
  lvl2_wipe_a: assert property (
    lvl2_seen ##0 wipe_asked |=> o_accept)
    else $error("full erase refused at level two");
  lvl2_update_a: assert property (
    wipe_then_write |=> o_accept)
    else $error("update after full erase refused");
  lvl2_stale_a: assert property (
    (level_dec != crg_pkg::CRG_LVL_TWO) ##1 lvl2_seen ##0 write_asked
    |=> o_refuse)
    else $error("update without full erase at level two");

  lvl3_loader_a: assert property (
    lvl3_seen ##0 (i_req.valid && !i_sw_loader_call) |=> o_refuse)
    else $error("loader open at level three");
  override_off_a: assert property (
    lvl3_seen |=> !o_override_en)
    else $error("override honoured at level three");
  override_low_a: assert property (
    !i_loader_override_pin |=> !o_override_en)
    else $error("override shown with the pin low");
  override_open_a: assert property (
    (level_dec != crg_pkg::CRG_LVL_THREE && i_loader_override_pin)
    |=> o_override_en)
    else $error("override lost below level three");
  sw_call_a: assert property (
    lvl3_seen ##0 (i_req.valid && i_sw_loader_call) |=> o_accept)
    else $error("software loader call refused");
  no_test_a: assert property (
    lvl3_seen |=> !o_test_en && !o_jtag_en)
    else $error("test access at level three");
  open_part_a: assert property (
    open_seen ##0 i_req.valid |=> o_accept && o_jtag_en)
    else $error("unprotected part restricted");

endmodule : crg_gate
`default_nettype wire

// *** verif/crg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Loader host
// ----
module crg_host_model (
  input wire logic i_sys_clk,
  input wire logic i_accept,
  input wire logic i_refuse,
  output crg_pkg::crg_req_s o_req
);
  initial o_req = '0;
  task send(input logic [2:0] c, input logic [4:0] s,
            output logic [1:0] ans);
    @(negedge i_sys_clk);
    o_req = '{valid: 1'b1, cmd: c, sector: s};
    @(negedge i_sys_clk);
    ans = {i_accept, i_refuse};
    o_req = '{valid: 1'b0, cmd: ~c, sector: ~s};
  endtask : send
endmodule : crg_host_model
`default_nettype wire

// *** verif/code_read_protection_gate_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module code_read_protection_gate_tb;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [31:0] word = 32'hFFFFFFFF;
  logic ovr = 1'b0;
  logic swc = 1'b0;
  logic swp = 1'b0;
  crg_pkg::crg_req_s req;
  logic jtag, ovr_en, tst, gnt, acc, rfs;
  logic [3:0] lvl;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  crg_gate dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_guard_word(word), .i_loader_override_pin(ovr),
    .i_sw_loader_call(swc), .i_sw_prog_req(swp), .i_req(req),
    .o_jtag_en(jtag), .o_override_en(ovr_en), .o_test_en(tst),
    .o_sw_prog_grant(gnt), .o_accept(acc), .o_refuse(rfs),
    .o_level(lvl));
  crg_host_model host (.i_sys_clk(i_sys_clk), .i_accept(acc),
    .i_refuse(rfs), .o_req(req));
  task final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task lvl_set(input logic [31:0] w);
    @(negedge i_sys_clk);
    word = w;
    repeat (2) @(negedge i_sys_clk);
  endtask : lvl_set
  task rq(input logic [2:0] c, input logic [4:0] s, input logic [1:0] e);
    logic [1:0] a;
    host.send(c, s, a);
    chk({2'h0, a}, {2'h0, e});
  endtask : rq
  task t_none;
    lvl_set(32'hFFFFFFFF);
    chk(lvl, 4'h1);
    chk({jtag, tst, ovr_en, gnt}, 4'hF);
    for (int c = 0; c < 6; c++) rq(c[2:0], 5'h00, 2'h2);
  endtask : t_none
  task t_one;
    lvl_set(crg_pkg::LEVEL_ONE_PATTERN);
    chk(lvl, 4'h2);
    chk({jtag, tst, ovr_en, gnt}, 4'h7);
    rq(crg_pkg::CMD_WRITE, 5'h00, 2'h1);
    rq(crg_pkg::CMD_WRITE, 5'h01, 2'h2);
    rq(crg_pkg::CMD_ERASE_PART, 5'h00, 2'h1);
    rq(crg_pkg::CMD_ERASE_PART, 5'h1F, 2'h2);
    rq(crg_pkg::CMD_ERASE_ALL, 5'h01, 2'h1);
    rq(crg_pkg::CMD_READ, 5'h01, 2'h1);
    rq(crg_pkg::CMD_GO, 5'h01, 2'h2);
    rq(crg_pkg::CMD_INFO, 5'h01, 2'h2);
  endtask : t_one
  task t_two;
    lvl_set(crg_pkg::LEVEL_TWO_PATTERN);
    chk(lvl, 4'h4);
    chk({jtag, tst, ovr_en, gnt}, 4'h7);
    rq(crg_pkg::CMD_WRITE, 5'h01, 2'h1);
    rq(crg_pkg::CMD_ERASE_PART, 5'h01, 2'h1);
    rq(crg_pkg::CMD_READ, 5'h01, 2'h1);
    rq(crg_pkg::CMD_GO, 5'h01, 2'h1);
    rq(crg_pkg::CMD_INFO, 5'h01, 2'h2);
    rq(crg_pkg::CMD_ERASE_ALL, 5'h00, 2'h2);
    rq(crg_pkg::CMD_WRITE, 5'h00, 2'h2);
    lvl_set(32'hFFFFFFFF);
    lvl_set(crg_pkg::LEVEL_TWO_PATTERN);
    rq(crg_pkg::CMD_WRITE, 5'h01, 2'h1);
  endtask : t_two
  task t_three;
    lvl_set(crg_pkg::LEVEL_THREE_PATTERN);
    chk(lvl, 4'h8);
    chk({jtag, tst, ovr_en, gnt}, 4'h1);
    for (int c = 0; c < 6; c++) rq(c[2:0], 5'h01, 2'h1);
    swc = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    rq(crg_pkg::CMD_WRITE, 5'h00, 2'h2);
    rq(crg_pkg::CMD_ERASE_ALL, 5'h00, 2'h2);
    chk({jtag, tst, ovr_en, gnt}, 4'h1);
    i_arst_n = 1'b0;
    @(negedge i_sys_clk);
    chk(lvl, 4'h8);
    chk({jtag, tst, ovr_en, gnt}, 4'h0);
    word = 32'hFFFFFFFF;
    swc = 1'b0;
    i_arst_n = 1'b1;
    @(negedge i_sys_clk);
    chk(lvl, 4'h1);
    chk({jtag, tst, ovr_en, gnt}, 4'hF);
    rq(crg_pkg::CMD_READ, 5'h00, 2'h2);
  endtask : t_three
  task t_pins;
    lvl_set(crg_pkg::LEVEL_ONE_PATTERN);
    ovr = 1'b0;
    swp = 1'b0;
    @(negedge i_sys_clk);
    chk({jtag, tst, ovr_en, gnt}, 4'h4);
    ovr = 1'b1;
    swp = 1'b1;
    @(negedge i_sys_clk);
    chk({jtag, tst, ovr_en, gnt}, 4'h7);
  endtask : t_pins
  task t_stale;
    logic [1:0] a;
    lvl_set(32'hFFFFFFFF);
    rq(crg_pkg::CMD_ERASE_ALL, 5'h00, 2'h2);
    // Level two and the write arrive in the same cycle
    fork
      host.send(crg_pkg::CMD_WRITE, 5'h01, a);
      begin
        @(negedge i_sys_clk);
        word = crg_pkg::LEVEL_TWO_PATTERN;
      end
    join
    chk({2'h0, a}, 4'h1);
  endtask : t_stale
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    ovr = 1'b1;
    swp = 1'b1;
    t_none();
    t_one();
    t_pins();
    t_two();
    t_stale();
    t_three();
    final_report();
  end
endmodule : code_read_protection_gate_tb
`default_nettype wire
